// *** verilog/tmc_timer.sv ***
// 8/16-bit timer/counter with buffered high byte, APB register slave.
// Assumes an APB master, one clock, external count pin synchronised here.
//
// Added by the designer: the APB slave port and the placing of the registers.
module tmc_timer #(
    parameter int unsigned INSTR_DIV = tmc_pkg::TMC_INSTR_DIV
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        external_count_input_i,
    output logic             overflow_o
);

    localparam int unsigned DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

    function automatic logic [2:0] tmc_decode(input logic [7:0] addr);
        logic [2:0] sel;
        sel = tmc_pkg::TMC_SEL_NONE;
        case (addr)
            tmc_pkg::TMC_OFF_CTRL:   sel = tmc_pkg::TMC_SEL_CTRL;
            tmc_pkg::TMC_OFF_CNT_LO: sel = tmc_pkg::TMC_SEL_CNT_LO;
            tmc_pkg::TMC_OFF_BUF_HI: sel = tmc_pkg::TMC_SEL_BUF_HI;
            tmc_pkg::TMC_OFF_STATUS: sel = tmc_pkg::TMC_SEL_STATUS;
            default:                 sel = tmc_pkg::TMC_SEL_NONE;
        endcase
        return sel;
    endfunction : tmc_decode

    function automatic logic [7:0] tmc_ps_mask(input logic [2:0] ratio);
        logic [8:0] one_hot;
        one_hot = 9'h001 << ({1'b0, ratio} + 4'h1);
        return one_hot[7:0] - 8'h01;
    endfunction : tmc_ps_mask

    // Instruction clock divider
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic             instr_tick;

    assign instr_tick = (div_q == DIV_W'(INSTR_DIV - 1));

    always_comb begin
        div_d = instr_tick ? '0 : div_q + 1'b1;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // APB slave: one wait-free access phase, answer registered at setup
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        setup;
    logic        wr_acc;
    logic [2:0]  sel;
    logic        wr_ctrl;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_stat;
    logic        rd_lo;

    logic [7:0]  ctrl_q;
    logic [7:0]  ctrl_d;
    logic [7:0]  cnt_lo_q;
    logic [7:0]  cnt_lo_d;
    logic [7:0]  cnt_hi_q;
    logic [7:0]  cnt_hi_d;
    logic [7:0]  buf_hi_q;
    logic [7:0]  buf_hi_d;
    logic [7:0]  ps_cnt_q;
    logic [7:0]  ps_cnt_d;
    logic [1:0]  hold_q;
    logic [1:0]  hold_d;
    logic        ovf_q;
    logic        ovf_d;

    assign sel     = tmc_decode(paddr_i);
    assign setup   = psel_i & ~penable_i;
    assign wr_acc  = psel_i & penable_i & pready_q & pwrite_i;
    assign wr_ctrl = wr_acc & (sel == tmc_pkg::TMC_SEL_CTRL);
    assign wr_lo   = wr_acc & (sel == tmc_pkg::TMC_SEL_CNT_LO);
    assign wr_hi   = wr_acc & (sel == tmc_pkg::TMC_SEL_BUF_HI);
    assign wr_stat = wr_acc & (sel == tmc_pkg::TMC_SEL_STATUS);
    assign rd_lo   = setup & ~pwrite_i & (sel == tmc_pkg::TMC_SEL_CNT_LO);

    always_comb begin
        pready_d  = setup;
        pslverr_d = setup & (sel == tmc_pkg::TMC_SEL_NONE);
        prdata_d  = prdata_q;
        if (setup) begin
            prdata_d = '0;
            if (!pwrite_i) begin
                case (sel)
                    tmc_pkg::TMC_SEL_CTRL:   prdata_d[7:0] = ctrl_q;
                    tmc_pkg::TMC_SEL_CNT_LO: prdata_d[7:0] = cnt_lo_q;
                    tmc_pkg::TMC_SEL_BUF_HI: prdata_d[7:0] = buf_hi_q;
                    tmc_pkg::TMC_SEL_STATUS:
                        prdata_d[tmc_pkg::TMC_STAT_OVF] = ovf_q;
                    default:                 prdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;

    // Counting
    logic       ext_edge;
    logic       mode16;
    logic       src_evt;
    logic       ps_hit;
    logic       cnt_inc;
    logic       wrap;
    logic [7:0] ps_mask;
    logic [15:0] cnt16;

    tmc_edge_sync u_edge (
        .clk_sys_i     (clk_sys_i),
        .sys_rst_i     (sys_rst_i),
        .pin_i         (external_count_input_i),
        .falling_sel_i (ctrl_q[tmc_pkg::TMC_CTRL_EDGE]),
        .edge_o        (ext_edge)
    );

    assign mode16  = ~ctrl_q[tmc_pkg::TMC_CTRL_MODE8];
    assign cnt16   = {cnt_hi_q, cnt_lo_q};
    assign ps_mask = tmc_ps_mask(ctrl_q[tmc_pkg::TMC_CTRL_PS_LSB +:
                                        tmc_pkg::TMC_CTRL_PS_W]);
    assign src_evt = ctrl_q[tmc_pkg::TMC_CTRL_EN] &
                     (ctrl_q[tmc_pkg::TMC_CTRL_SRC] ? ext_edge
                                                    : instr_tick);
    assign ps_hit  = ctrl_q[tmc_pkg::TMC_CTRL_BYPASS] |
                     ((ps_cnt_q & ps_mask) == ps_mask);
    assign cnt_inc = src_evt & ps_hit & (hold_q == 2'h0) & ~wr_lo;
    assign wrap    = cnt_inc & (cnt_lo_q == 8'hFF) &
                     (~mode16 | (cnt_hi_q == 8'hFF));

    always_comb begin
        ctrl_d   = wr_ctrl ? pwdata_i[7:0] : ctrl_q;
        ps_cnt_d = ps_cnt_q;
        hold_d   = hold_q;
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        buf_hi_d = buf_hi_q;
        ovf_d    = (ovf_q & ~(wr_stat & pwdata_i[tmc_pkg::TMC_STAT_OVF]))
                   | wrap;
        if (wr_lo) begin
            ps_cnt_d = '0;
            hold_d   = tmc_pkg::TMC_INHIBIT_CYC;
        end else begin
            if (src_evt && !ctrl_q[tmc_pkg::TMC_CTRL_BYPASS]) begin
                ps_cnt_d = ps_cnt_q + 8'h01;
            end
            if (instr_tick && hold_q != 2'h0) begin
                hold_d = hold_q - 2'h1;
            end
        end
        if (wr_lo) begin
            cnt_lo_d = pwdata_i[7:0];
            if (mode16) begin
                cnt_hi_d = buf_hi_q;
            end
        end else if (cnt_inc) begin
            if (mode16) begin
                {cnt_hi_d, cnt_lo_d} = cnt16 + 16'h0001;
            end else begin
                cnt_lo_d = cnt_lo_q + 8'h01;
            end
        end
        if (wr_hi) begin
            buf_hi_d = pwdata_i[7:0];
        end else if (rd_lo && mode16) begin
            buf_hi_d = cnt_hi_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q   <= tmc_pkg::TMC_CTRL_RST;
            ps_cnt_q <= '0;
            hold_q   <= '0;
            cnt_lo_q <= tmc_pkg::TMC_CNT_RST;
            cnt_hi_q <= tmc_pkg::TMC_CNT_RST;
            buf_hi_q <= tmc_pkg::TMC_CNT_RST;
            ovf_q    <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            ps_cnt_q <= ps_cnt_d;
            hold_q   <= hold_d;
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
            buf_hi_q <= buf_hi_d;
            ovf_q    <= ovf_d;
        end
    end

    assign overflow_o = ovf_q;

    property p_timer_step;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ctrl_q[tmc_pkg::TMC_CTRL_EN] && !ctrl_q[tmc_pkg::TMC_CTRL_SRC]
         && ctrl_q[tmc_pkg::TMC_CTRL_BYPASS] && mode16 && instr_tick
         && hold_q == 2'h0 && !wr_lo) |=> cnt16 == $past(cnt16) + 16'h0001;
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer mode did not step on instruction tick");

    property p_src_ignores_tick;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ctrl_q[tmc_pkg::TMC_CTRL_SRC] && !ext_edge && !wr_lo)
        |=> $stable(cnt16);
    endproperty
    a_src_ignores_tick: assert property (p_src_ignores_tick)
        else $error("counter mode moved without a pin edge");

    property p_edge_count;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (ctrl_q[tmc_pkg::TMC_CTRL_EN] && ctrl_q[tmc_pkg::TMC_CTRL_SRC]
         && ctrl_q[tmc_pkg::TMC_CTRL_BYPASS] && mode16 && ext_edge
         && hold_q == 2'h0 && !wr_lo) |=> cnt16 == $past(cnt16) + 16'h0001;
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("pin edge not counted");

    property p_inhibit_len;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wr_lo |=> (hold_q != 2'h0)[*5];
    endproperty
    a_inhibit_len: assert property (p_inhibit_len)
        else $error("count inhibit shorter than two instruction cycles");

    property p_inhibit_hold;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (hold_q != 2'h0 && !wr_lo) |=> $stable(cnt16);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold)
        else $error("count moved during inhibit");

    property p_buf_write_no_effect;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (wr_hi && !cnt_inc) |=> $stable(cnt16);
    endproperty
    a_buf_write_no_effect: assert property (p_buf_write_no_effect)
        else $error("buffer write changed the running count");

    property p_snapshot;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (rd_lo && mode16) |=> buf_hi_q == $past(cnt_hi_q)
                              && prdata_q[7:0] == $past(cnt_lo_q);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("low byte read did not capture high byte");

    property p_load16;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (wr_lo && mode16) |=>
            cnt16 == {$past(buf_hi_q), $past(pwdata_i[7:0])};
    endproperty
    a_load16: assert property (p_load16)
        else $error("low byte write did not load sixteen bits");

    property p_overflow;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (cnt_inc && mode16 && cnt16 == 16'hFFFF) |=> ovf_q && cnt16 == '0;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("wrap did not set overflow");

    property p_hidden_high;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!mode16 && !$past(mode16)) |-> $stable(cnt_hi_q);
    endproperty
    a_hidden_high: assert property (p_hidden_high)
        else $error("upper byte moved in 8-bit mode");

endmodule : tmc_timer

// *** inc/tmc_pkg.sv ***
// Constants and register map of the 8/16-bit timer/counter.
// Assumes an APB slave with one 32-bit word per register.
package tmc_pkg;

    // Register byte offsets
    localparam logic [7:0]  TMC_OFF_CTRL    = 8'h00;
    localparam logic [7:0]  TMC_OFF_CNT_LO  = 8'h04;
    localparam logic [7:0]  TMC_OFF_BUF_HI  = 8'h08;
    localparam logic [7:0]  TMC_OFF_STATUS  = 8'h0C;

    // Decoded register selectors
    localparam logic [2:0]  TMC_SEL_CTRL    = 3'h0;
    localparam logic [2:0]  TMC_SEL_CNT_LO  = 3'h1;
    localparam logic [2:0]  TMC_SEL_BUF_HI  = 3'h2;
    localparam logic [2:0]  TMC_SEL_STATUS  = 3'h3;
    localparam logic [2:0]  TMC_SEL_NONE    = 3'h4;

    // Control register fields
    localparam int unsigned TMC_CTRL_PS_LSB = 0;
    localparam int unsigned TMC_CTRL_PS_W   = 3;
    localparam int unsigned TMC_CTRL_BYPASS = 3;
    localparam int unsigned TMC_CTRL_EDGE   = 4;
    localparam int unsigned TMC_CTRL_SRC    = 5;
    localparam int unsigned TMC_CTRL_MODE8  = 6;
    localparam int unsigned TMC_CTRL_EN     = 7;

    // Status register fields
    localparam int unsigned TMC_STAT_OVF    = 0;

    // Reset values
    localparam logic [7:0]  TMC_CTRL_RST    = 8'h08;
    localparam logic [7:0]  TMC_CNT_RST     = 8'h00;

    // Timing: system clocks per instruction cycle, inhibit length
    localparam int unsigned TMC_INSTR_DIV   = 4;
    localparam logic [1:0]  TMC_INHIBIT_CYC = 2'h2;

endpackage : tmc_pkg

// *** verilog/tmc_edge_sync.sv ***
// Synchroniser and edge selector for the external count input.
// Assumes the pin may change at any time relative to clk_sys_i.
module tmc_edge_sync (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    input  wire logic falling_sel_i,
    output logic      edge_o
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic edge_q;
    logic edge_d;

    always_comb begin
        // Rising edge unless falling selected
        if (falling_sel_i) begin
            edge_d = prev_q & ~sync2_q;
        end else begin
            edge_d = ~prev_q & sync2_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            edge_q  <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            edge_q  <= edge_d;
        end
    end

    assign edge_o = edge_q;

    property p_rise_latency;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!falling_sel_i && !pin_i) ##1 (pin_i && !falling_sel_i)[*3]
        |=> edge_q;
    endproperty
    a_rise_latency: assert property (p_rise_latency)
        else $error("rising pin edge not counted after sync latency");

endmodule : tmc_edge_sync

// *** tb/tmc_pin_src.sv ***
// Behavioural source for the external count pin.
// Assumes go_i is a one-cycle request; edges are four clocks apart.
module tmc_pin_src (
    input  wire logic       clk_sys_i,
    input  wire logic       go_i,
    input  wire logic [7:0] toggles_i,
    output logic            pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            if (go_i === 1'b1) begin
                busy_o <= 1'b1;
                for (int k = 0; k < toggles_i; k++) begin
                    repeat (4) @(posedge clk_sys_i);
                    pin_o <= ~pin_o;
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule : tmc_pin_src

// *** tb/tb_tmc_timer.sv ***
// Self-checking bench for the timer/counter over APB.
// Assumes one 40 ns clock and a zero-wait APB slave.
module tb_tmc_timer;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [32:0] e; logic [32:0] m;} tmc_note_t;
    localparam logic [32:0] ALL = 33'h1_ffff_ffff;
    localparam logic [32:0] ERR = 33'h1_0000_0000;
    logic clk_sys_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, go = 0, pin, busy, lvl = 0;
    logic [7:0]  paddr_i = 8'h00, tog = 8'h00, h, l, ch = 8'h00, cl = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd, a, lfsr = 32'h3bb6;
    logic pready_o, pslverr_o, overflow_o;
    int bad_count = 0, comparisons = 0, n;
    tmc_note_t q[$];
    tmc_note_t t;
    always #20 clk_sys_i = ~clk_sys_i;
    tmc_timer u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .external_count_input_i(pin), .overflow_o(overflow_o));
    tmc_pin_src u_pin (.clk_sys_i(clk_sys_i), .go_i(go), .toggles_i(tog),
        .pin_o(pin), .busy_o(busy));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction : nxt
    task automatic fail(input string s);
        bad_count++;
        $display("ERROR %0t %s", $time, s);
    endtask : fail
    task automatic chk(input logic c, input string s);
        comparisons++;
        if (c !== 1'b1) fail(s);
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        @(posedge clk_sys_i);
        q.push_back({e, m});
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= {24'h00_0000, d};
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        // Only pready_o or the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        apb(1'b1, ad, d, 33'h0, ERR);
    endtask : wr
    task automatic rdc(input logic [7:0] ad, input logic [7:0] d);
        apb(1'b0, ad, 8'h00, {25'h0, d}, ALL);
    endtask : rdc
    // Monitor: each completed transfer pops the oldest note and is checked against it if its mask is nonzero
    always @(posedge clk_sys_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && q.size() > 0) begin
            t = q.pop_front();
            if (t.m != 33'h0) begin
                comparisons++;
                if ((({pslverr_o, prdata_o} ^ t.e) & t.m) !== 33'h0)
                    fail($sformatf("addr %h got %h", paddr_i, prdata_o));
            end
        end
    end
    task automatic stop_test;
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail("timeout");
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rdc(8'h00, 8'h08);
        rdc(8'h04, 8'h00);
        rdc(8'h08, 8'h00);
        rdc(8'h0C, 8'h00);
        apb(1'b1, 8'h10, 8'h55, ERR, ERR);
        apb(1'b0, 8'h10, 8'h00, ERR, ALL);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            h = lfsr[7:0];
            l = lfsr[15:8];
            wr(8'h08, h);
            rdc(8'h08, h);
            rdc(8'h04, cl);
            rdc(8'h08, ch);
            wr(8'h08, h);
            wr(8'h04, l);
            rdc(8'h04, l);
            rdc(8'h08, h);
            ch = h;
            cl = l;
        end
        wr(8'h00, 8'h88);
        wr(8'h08, 8'h00);
        wr(8'h04, 8'h10);
        repeat (3) @(posedge clk_sys_i);
        rdc(8'h04, 8'h10);
        for (int p = 0; p < 3; p++) begin
            wr(8'h00, (p == 0) ? 8'h88 : (8'h80 | 8'(p - 1)));
            apb(1'b0, 8'h04, 8'h00, 33'h0, 33'h0);
            a = rd;
            repeat (80) @(posedge clk_sys_i);
            apb(1'b0, 8'h04, 8'h00, 33'h0, 33'h0);
            n = int'(8'(rd[7:0] - a[7:0]));
            // 83 clocks between captures; 4, 8 or 16 clocks per step
            chk(n >= 83 / (4 << p) && n <= 83 / (4 << p) + 1, "rate");
        end
        wr(8'h00, 8'h48);
        wr(8'h0C, 8'h01);
        wr(8'h08, 8'h33);
        wr(8'h04, 8'hFD);
        rdc(8'h04, 8'hFD);
        rdc(8'h08, 8'h33);
        chk(overflow_o === 1'b0, "ovf early");
        wr(8'h00, 8'hC8);
        repeat (40) @(posedge clk_sys_i);
        chk(overflow_o === 1'b1, "ovf 8-bit");
        rdc(8'h0C, 8'h01);
        wr(8'h00, 8'h08);
        wr(8'h0C, 8'h01);
        rdc(8'h0C, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h04, 8'hFE);
        wr(8'h00, 8'h88);
        repeat (40) @(posedge clk_sys_i);
        chk(overflow_o === 1'b0, "ovf low wrap");
        wr(8'h00, 8'h08);
        apb(1'b0, 8'h04, 8'h00, 33'h0, 33'h0);
        rdc(8'h08, 8'h01);
        wr(8'h08, 8'hFF);
        wr(8'h04, 8'hF8);
        wr(8'h00, 8'h88);
        repeat (60) @(posedge clk_sys_i);
        chk(overflow_o === 1'b1, "ovf 16-bit");
        for (int e = 0; e < 2; e++) begin
            wr(8'h00, e ? 8'hB8 : 8'hA8);
            wr(8'h08, 8'h00);
            wr(8'h04, 8'h00);
            repeat (12) @(posedge clk_sys_i);
            lfsr = nxt(lfsr);
            n = int'(lfsr[3:0]) + 1;
            tog <= n[7:0];
            go <= 1'b1;
            @(posedge clk_sys_i);
            go <= 1'b0;
            repeat (4 * n + 20) @(posedge clk_sys_i);
            chk(busy === 1'b0, "pin source busy");
            a = ((lvl ^ e[0]) == 1'b0) ? (n + 1) / 2 : n / 2;
            rdc(8'h04, a[7:0]);
            lvl = lvl ^ n[0];
        end
        stop_test();
    end
endmodule : tb_tmc_timer
